// >>> hw/qpg_consts.svh
`ifndef QPG_CONSTS_SVH
`define QPG_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define QPG_AW             8
`define QPG_OFF_CTRL       8'h00
`define QPG_OFF_PERIOD     8'h04
`define QPG_OFF_STATUS     8'h08
`define QPG_OFF_DUTY_FIRST 8'h10
`define QPG_OFF_DUTY_LAST  8'h4C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define QPG_CTRL_EN        0
`define QPG_CTRL_ALIGN     1
`define QPG_CTRL_DBL       2
`define QPG_CTRL_PAIR_LSB  4
`define QPG_CTRL_PAIR_MSB  7
`define QPG_CTRL_RST       8'h00
`define QPG_PERIOD_RST     16'h0000
`define QPG_DUTY_RST       16'h0000
`define QPG_CNT_ZERO       16'h0000
`define QPG_CNT_ONE        16'h0001
`define QPG_STAT_DOWN      0
`define QPG_STAT_CNT_LSB   16

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define QPG_RESP_OKAY      2'h0
`define QPG_RESP_SLVERR    2'h2

`endif

// >>> hw/qpg_group.sv
`timescale 1ns/1ps
`include "qpg_consts.svh"

module qpg_group (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // timebase
    input  wire logic        i_load,
    input  wire logic        i_en,
    input  wire logic        i_paired,
    input  wire logic [15:0] i_cmp,
    // shadow duties, channel 0 in the low bits
    input  wire logic [63:0] i_duty,
    // outputs
    output logic      [3:0]  o_pwm
);

    qpg_pkg::qpg_word_t duty_act_q [4];
    logic [3:0]         lvl;
    logic [3:0]         pwm_d;

    function automatic logic hit(input logic [15:0] cmp,
                                 input logic [15:0] duty);
        return cmp < duty;
    endfunction : hit

    // ------------------------------------------------------------------
    // shadow to active transfer only at the update instant
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 4; c++) begin
                duty_act_q[c] <= `QPG_DUTY_RST;
            end
        end else if (i_load) begin
            for (int c = 0; c < 4; c++) begin
                duty_act_q[c] <= i_duty[c*16 +: 16];
            end
        end
    end

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            lvl[c] = hit(i_cmp, duty_act_q[c]);
        end
        if (!i_en) begin
            pwm_d = 4'h0;
        end else if (i_paired) begin
            // two complementary pairs: outputs 0/1 and 2/3
            pwm_d = {~lvl[2], lvl[2], ~lvl[0], lvl[0]};
        end else begin
            pwm_d = lvl;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pwm <= 4'h0;
        end else begin
            o_pwm <= pwm_d;
        end
    end

endmodule : qpg_group

// >>> hw/qpg_pkg.sv
package qpg_pkg;

    // ------------------------------------------------------------------
    // modes and counter phase
    // ------------------------------------------------------------------
    typedef enum logic {
        QPG_EDGE   = 1'b0,
        QPG_CENTER = 1'b1
    } qpg_align_t;

    typedef enum logic {
        QPG_UP   = 1'b0,
        QPG_DOWN = 1'b1
    } qpg_phase_t;

    typedef logic [15:0] qpg_word_t;

endpackage : qpg_pkg

// >>> hw/qpg_top.sv
`timescale 1ns/1ps
`include "qpg_consts.svh"

// Behaviour
// - sixteen outputs, four groups of four outputs each.
// - each paired group forms two pairs from adjacent outputs.
// - alignment selectable: centered pulses or edge-aligned pulses.
// - paired groups drive complementary levels; unpaired ones independent.
// - paired or unpaired is chosen per group, not globally.
// - center-aligned mode offers single-update and double-update regimes.
// - single update: new duties taken once per period, symmetric pulses.
// - double update: duties also reloaded at mid-period, asymmetric allowed.
module qpg_top (
    // clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_RSTN,
    // write address channel
    input  wire logic                I_AWVALID,
    output logic                     O_AWREADY,
    input  wire logic [`QPG_AW-1:0]  I_AWADDR,
    // write data channel
    input  wire logic                I_WVALID,
    output logic                     O_WREADY,
    input  wire logic [31:0]         I_WDATA,
    input  wire logic [3:0]          I_WSTRB,
    // write response channel
    output logic                     O_BVALID,
    input  wire logic                I_BREADY,
    output logic [1:0]               O_BRESP,
    // read address channel
    input  wire logic                I_ARVALID,
    output logic                     O_ARREADY,
    input  wire logic [`QPG_AW-1:0]  I_ARADDR,
    // read data channel
    output logic                     O_RVALID,
    input  wire logic                I_RREADY,
    output logic [31:0]              O_RDATA,
    output logic [1:0]               O_RRESP,
    // pwm outputs, group g on bits 4g+3..4g
    output logic [15:0]              O_PWM
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0]           ctrl_q, ctrl_act_q;
    qpg_pkg::qpg_word_t   period_q, period_act_q;
    qpg_pkg::qpg_word_t   duty_q [16];
    qpg_pkg::qpg_word_t   cnt_q, cnt_d;
    qpg_pkg::qpg_phase_t  phase_q, phase_d;
    qpg_pkg::qpg_align_t  align;
    qpg_pkg::qpg_word_t   top, cmp;
    logic                 en, dbl, period_end, mid_load, load;
    logic                 aw_full_q, w_full_q, do_write, rd_take, rd_ok;
    logic [`QPG_AW-1:0]   awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic [31:0]          rd_val;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_duty(input logic [`QPG_AW-1:0] a);
        return a >= `QPG_OFF_DUTY_FIRST && a <= `QPG_OFF_DUTY_LAST
            && a[1:0] == 2'h0;
    endfunction : is_duty
    function automatic logic [3:0] duty_idx(input logic [`QPG_AW-1:0] a);
        logic [`QPG_AW-1:0] d;
        d = a - `QPG_OFF_DUTY_FIRST;
        return d[5:2];
    endfunction : duty_idx
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // write path
    // ------------------------------------------------------------------
    assign O_AWREADY = !aw_full_q && !O_BVALID;
    assign O_WREADY  = !w_full_q && !O_BVALID;
    assign do_write  = aw_full_q && w_full_q && !O_BVALID;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= I_AWADDR;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (I_WVALID && O_WREADY) begin
            w_full_q <= 1'b1;
            wdata_q  <= I_WDATA;
            wstrb_q  <= I_WSTRB;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= `QPG_RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= (awaddr_q == `QPG_OFF_CTRL
                         || awaddr_q == `QPG_OFF_PERIOD
                         || awaddr_q == `QPG_OFF_STATUS
                         || is_duty(awaddr_q))
                        ? `QPG_RESP_OKAY : `QPG_RESP_SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // software registers (shadow side)
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q   <= `QPG_CTRL_RST;
            period_q <= `QPG_PERIOD_RST;
        end else if (do_write) begin
            if (awaddr_q == `QPG_OFF_CTRL) begin
                ctrl_q <= 8'(merge({24'h00_0000, ctrl_q}, wdata_q, wstrb_q));
            end
            if (awaddr_q == `QPG_OFF_PERIOD) begin
                period_q <= 16'(merge({16'h0000, period_q}, wdata_q,
                                      wstrb_q));
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < 16; i++) begin
                duty_q[i] <= `QPG_DUTY_RST;
            end
        end else if (do_write && is_duty(awaddr_q)) begin
            duty_q[duty_idx(awaddr_q)] <= 16'(merge(
                {16'h0000, duty_q[duty_idx(awaddr_q)]}, wdata_q, wstrb_q));
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    assign O_ARREADY = !O_RVALID;
    assign rd_take   = I_ARVALID && O_ARREADY;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (I_ARADDR == `QPG_OFF_CTRL) begin
            rd_val[7:0] = ctrl_q;
        end else if (I_ARADDR == `QPG_OFF_PERIOD) begin
            rd_val[15:0] = period_q;
        end else if (I_ARADDR == `QPG_OFF_STATUS) begin
            rd_val[`QPG_STAT_DOWN] = (phase_q == qpg_pkg::QPG_DOWN);
            rd_val[`QPG_STAT_CNT_LSB +: 16] = cnt_q;
        end else if (is_duty(I_ARADDR)) begin
            rd_val[15:0] = duty_q[duty_idx(I_ARADDR)];
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0000_0000;
            O_RRESP  <= `QPG_RESP_OKAY;
        end else if (rd_take) begin
            O_RVALID <= 1'b1;
            O_RDATA  <= rd_val;
            O_RRESP  <= rd_ok ? `QPG_RESP_OKAY : `QPG_RESP_SLVERR;
        end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------------
    assign en    = ctrl_act_q[`QPG_CTRL_EN];
    assign align = qpg_pkg::qpg_align_t'(ctrl_act_q[`QPG_CTRL_ALIGN]);
    assign dbl   = ctrl_act_q[`QPG_CTRL_DBL];
    assign top   = (period_act_q == `QPG_CNT_ZERO)
                   ? `QPG_CNT_ZERO : period_act_q - `QPG_CNT_ONE;

    always_comb begin
        cnt_d   = cnt_q;
        phase_d = phase_q;
        if (!en) begin
            cnt_d   = `QPG_CNT_ZERO;
            phase_d = qpg_pkg::QPG_UP;
        end else begin
            unique case (align)
                qpg_pkg::QPG_EDGE: begin
                    cnt_d   = (cnt_q >= top) ? `QPG_CNT_ZERO
                                             : cnt_q + `QPG_CNT_ONE;
                    phase_d = qpg_pkg::QPG_UP;
                end
                qpg_pkg::QPG_CENTER: begin
                    // up 0..top, then down top..0; each end held once
                    if (phase_q == qpg_pkg::QPG_UP) begin
                        if (cnt_q >= top) begin
                            phase_d = qpg_pkg::QPG_DOWN;
                        end else begin
                            cnt_d = cnt_q + `QPG_CNT_ONE;
                        end
                    end else if (cnt_q == `QPG_CNT_ZERO) begin
                        phase_d = qpg_pkg::QPG_UP;
                    end else begin
                        cnt_d = cnt_q - `QPG_CNT_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cnt_q   <= `QPG_CNT_ZERO;
            phase_q <= qpg_pkg::QPG_UP;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // update instants
    // ------------------------------------------------------------------
    always_comb begin
        if (!en) begin
            period_end = 1'b1;
        end else if (align == qpg_pkg::QPG_EDGE) begin
            period_end = cnt_q >= top;
        end else begin
            period_end = phase_q == qpg_pkg::QPG_DOWN
                         && cnt_q == `QPG_CNT_ZERO;
        end
    end

    assign mid_load = en && align == qpg_pkg::QPG_CENTER && dbl
                      && phase_q == qpg_pkg::QPG_UP
                      && cnt_q >= top;
    assign load     = period_end || mid_load;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_act_q   <= `QPG_CTRL_RST;
            period_act_q <= `QPG_PERIOD_RST;
        end else if (period_end) begin
            ctrl_act_q   <= ctrl_q;
            period_act_q <= period_q;
        end
    end

    // centered pulses compare against the distance to the top
    assign cmp = (align == qpg_pkg::QPG_CENTER) ? top - cnt_q : cnt_q;

    // ------------------------------------------------------------------
    // four groups of four outputs
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_grp
        qpg_group u_grp (
            .i_clk    (I_CLK),
            .i_rstn   (I_RSTN),
            .i_load   (load),
            .i_en     (en),
            .i_paired (ctrl_act_q[`QPG_CTRL_PAIR_LSB + g]),
            .i_cmp    (cmp),
            .i_duty   ({duty_q[4*g+3], duty_q[4*g+2],
                        duty_q[4*g+1], duty_q[4*g]}),
            .o_pwm    (O_PWM[4*g +: 4])
        );
    end

endmodule : qpg_top

// >>> testbench/qpg_load_model.sv
`timescale 1ns/1ps

module qpg_load_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // switch drive levels
    input  wire logic [15:0] i_pwm,
    // last on and off times per switch, in clocks
    output int               o_hi [16],
    output int               o_lo [16]
);
    logic [15:0] lvl_q;
    int          run_q [16];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_q <= 16'h0000;
            for (int k = 0; k < 16; k++) begin
                run_q[k] <= 0;
                o_hi[k]  <= 0;
                o_lo[k]  <= 0;
            end
        end else begin
            lvl_q <= i_pwm;
            for (int k = 0; k < 16; k++) begin
                if (i_pwm[k] !== lvl_q[k]) begin
                    run_q[k] <= 1;
                    if (lvl_q[k]) o_hi[k] <= run_q[k];
                    else o_lo[k] <= run_q[k];
                end else begin
                    run_q[k] <= run_q[k] + 1;
                end
            end
        end
    end
endmodule : qpg_load_model

// >>> testbench/qpg_top_props.sv
`timescale 1ns/1ps
`include "qpg_consts.svh"

module qpg_top_props (
    // clock and reset
    input wire logic               I_CLK,
    input wire logic               I_RSTN,
    // register bus
    input wire logic               I_AWVALID,
    input wire logic               O_AWREADY,
    input wire logic               I_WVALID,
    input wire logic               O_WREADY,
    input wire logic               O_BVALID,
    input wire logic               I_BREADY,
    input wire logic [1:0]         O_BRESP,
    input wire logic               I_ARVALID,
    input wire logic               O_ARREADY,
    input wire logic [`QPG_AW-1:0] I_ARADDR,
    input wire logic               O_RVALID,
    input wire logic               I_RREADY,
    input wire logic [31:0]        O_RDATA,
    input wire logic [1:0]         O_RRESP,
    // outputs
    input wire logic [15:0]        O_PWM
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    property p_bhold;
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold;
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_arblock;
        O_RVALID |-> !O_ARREADY;
    endproperty
    a_arblock: assert property (p_arblock) else $error("read taken early");
    property p_wblock;
        O_BVALID |-> !O_AWREADY && !O_WREADY;
    endproperty
    a_wblock: assert property (p_wblock) else $error("write taken early");
    property p_rans;
        I_ARVALID && O_ARREADY |=> O_RVALID;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_unmapped;
        I_ARVALID && O_ARREADY && I_ARADDR > 8'h4C |=> O_RRESP == 2'h2;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slverr");
    property p_bdrop;
        O_BVALID && I_BREADY |=> !O_BVALID ##1 !O_BVALID;
    endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer repeats");
    property p_pwm_idle;
        $rose(I_RSTN) |-> (O_PWM == 16'h0000) [*2];
    endproperty
    a_pwm_idle: assert property (p_pwm_idle) else $error("pwm on at start");
endmodule : qpg_top_props

bind qpg_top qpg_top_props u_props (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_PWM(O_PWM));

// >>> testbench/tb.sv
`timescale 1ns/1ps

module tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0]  ws = 4'hF;
    logic        awr, wr, bv, arr, rv;
    logic [1:0]  br, rr, r;
    logic [31:0] rd, v;
    logic [15:0] pwm;
    int          hi [16];
    int          lo [16];
    int          d [16];
    int          error_cnt = 0;
    int          compares = 0;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h4C, 8'h0C, 8'h50};

    always #2.5 clk = ~clk;

    qpg_top dut (.I_CLK(clk), .I_RSTN(rstn), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr),
        .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry),
        .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
        .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rd), .O_RRESP(rr),
        .O_PWM(pwm));
    qpg_load_model load (.i_clk(clk), .i_rstn(rstn), .i_pwm(pwm),
        .o_hi(hi), .o_lo(lo));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat,
                          output logic [1:0] resp);
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv  <= 1'b1;
        wd  <= dat;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!bv);
        resp = br;
        bry <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] dat,
                          output logic [1:0] resp);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        dat = rd;
        resp = rr;
        rry <= 1'b0;
    endtask : rd_reg

    task automatic prog_pwm(int p, bit ctr, bit dbl, logic [3:0] pm);
        wr_reg(8'h04, 32'(p), r);
        for (int k = 0; k < 16; k++) wr_reg(8'(8'h10 + 4*k), 32'(d[k]), r);
        wr_reg(8'h00, {24'h00_0000, pm, 1'b0, dbl, ctr, 1'b1}, r);
    endtask : prog_pwm

    task automatic check_widths(int p, bit ctr, logic [3:0] pm);
        int per, m, e;
        per = ctr ? 2*p : p;
        m = ctr ? 2 : 1;
        repeat (4*per) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            e = (pm[k/4] && k%2) ? per - m*d[k-1] : m*d[k];
            chk("pulse high", hi[k], e);
            chk("pulse low", lo[k], per - e);
        end
    endtask : check_widths

    task automatic wait_lvl(logic lv);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pwm[0] !== lv && n < 500);
        if (n >= 500) error_cnt++;
    endtask : wait_lvl

    // duty drops from 10 to 3 while a center pulse is rising
    task automatic retune(bit dbl, int e1);
        d[0] = 10;
        prog_pwm(32, 1'b1, dbl, 4'h0);
        repeat (256) @(posedge clk);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        wr_reg(8'h10, 32'h0000_0003, r);
        wait_lvl(1'b0);
        @(posedge clk);
        chk("pulse across update", hi[0], e1);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        @(posedge clk);
        chk("pulse after update", hi[0], 6);
    endtask : retune

    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hffd5));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (ra[i]) begin
            rd_reg(ra[i], v, r);
            chk("reset read", v, 32'h0000_0000);
            chk("read resp", r, i > 4 ? 2'h2 : 2'h0);
        end
        wr_reg(8'h50, 32'hFFFF_FFFF, r);
        chk("unmapped write", r, 2'h2);
        ws <= 4'h1;
        wr_reg(8'h04, 32'h0000_1234, r);
        ws <= 4'hF;
        rd_reg(8'h04, v, r);
        chk("strobed write", v, 32'h0000_0034);
        foreach (d[k]) d[k] = $urandom_range(15, 1);
        prog_pwm(16, 1'b0, 1'b0, 4'b0101);
        rd_reg(8'h04, v, r);
        chk("period", v, 32'h0000_0010);
        check_widths(16, 1'b0, 4'b0101);
        foreach (d[k]) d[k] = $urandom_range(15, 1);
        prog_pwm(16, 1'b1, 1'b0, 4'b1010);
        check_widths(16, 1'b1, 4'b1010);
        retune(1'b0, 20);
        retune(1'b1, 13);
        report_and_stop();
    end

    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb
